/* logic/sse_defines.svh */
// Constants for the subtract and sleep execution block
`ifndef SSE_DEFINES_SVH
`define SSE_DEFINES_SVH
// ****************************************************************
// Register file and reset values
// ****************************************************************
`define SSE_REG_COUNT     128
`define SSE_REG_RST       8'h00
`define SSE_ADDR_W        7
`define SSE_ACC_RST       8'h00
`define SSE_WDT_RST       8'h00
`define SSE_PRE_RST       8'h00
`define SSE_FLAG_N_RST    1'h1
// ****************************************************************
// Status read word bit positions
// ****************************************************************
`define SSE_ST_CARRY      0
`define SSE_ST_NIBBLE     1
`define SSE_ST_ZERO       2
`define SSE_ST_PD_N       3
`define SSE_ST_TO_N       4
// ****************************************************************
// Register bus offsets
// ****************************************************************
`define SSE_OFF_ACC       8'h00
`define SSE_OFF_STATUS    8'h01
`define SSE_OFF_WDT       8'h02
`define SSE_OFF_PRE       8'h03
`endif

/* logic/sse_pkg.sv */
// Types for the subtract and sleep execution block
package sse_pkg;
    // Instruction selector
    typedef enum logic [1:0] {
        SSE_OP_LITERAL_MINUS_ACCUMULATOR,
        SSE_OP_REGISTER_MINUS_ACCUMULATOR,
        SSE_OP_REGISTER_MINUS_ACCUMULATOR_BORROW,
        SSE_OP_SLEEP
    } sse_op_type;
    // One instruction issue
    typedef struct packed {
        sse_op_type  op;
        logic [7:0]  literal;
        logic [6:0]  reg_addr;
        logic        dest;
    } sse_instr_type;
    // Core state
    typedef enum logic {
        SSE_RUN,
        SSE_SLEEP
    } sse_state_type;
endpackage : sse_pkg

/* logic/sse_exec.sv */
// Execution of the three subtract instructions and the power-down instruction
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "sse_defines.svh"

module sse_exec
    import sse_pkg::*;
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          sys_rst,
    // Instruction issue
    input  wire logic          instr_valid,
    input  wire sse_instr_type instr,
    // Wake event from outside the clock domain
    input  wire logic          wake_pin,
    // Watchdog tick from the same clock domain
    input  wire logic          wdt_tick,
    // Register bus
    input  wire logic [7:0]    bus_addr,
    input  wire logic [7:0]    bus_wdata,
    input  wire logic          bus_wr,
    input  wire logic          bus_rd,
    output logic [7:0]         bus_rdata,
    // Status and power outputs
    output logic [7:0]         accumulator,
    output logic               carry_flag,
    output logic               nibble_carry_flag,
    output logic               zero_flag,
    output logic               timeout_flag_n,
    output logic               powerdown_flag_n,
    output logic               osc_run,
    output logic               core_halted
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0]    regs_q [`SSE_REG_COUNT];
    logic [7:0]    acc_q;
    logic          c_q;
    logic          dc_q;
    logic          z_q;
    logic          to_n_q;
    logic          pd_n_q;
    logic [7:0]    wdt_q;
    logic [7:0]    pre_q;
    sse_state_type state_q;
    logic [1:0]    wake_sync_q;
    logic [7:0]    rdata_q;

    // ****************************************************************
    // Arithmetic
    // ****************************************************************
    logic [7:0] minuend;
    logic [8:0] diff;
    logic [4:0] ndiff;
    logic       borrow_in;
    logic       is_sub;
    logic       exec;

    // Instructions are ignored while asleep; exec is gated by the run state, and sys_clk keeps running
    assign exec   = instr_valid && (state_q == SSE_RUN);
    assign is_sub = exec && (instr.op != SSE_OP_SLEEP);

    // Minuend is the literal or the addressed register
    always_comb begin
        if (instr.op == SSE_OP_LITERAL_MINUS_ACCUMULATOR) begin
            minuend = instr.literal;
        end else begin
            minuend = regs_q[instr.reg_addr];
        end
    end

    // Borrow is the inverted carry, only for the borrow form
    assign borrow_in = (instr.op == SSE_OP_REGISTER_MINUS_ACCUMULATOR_BORROW) ? ~c_q : 1'b0;

    // Carry out of bit 7 set means no borrow, so accumulator did not exceed minuend
    assign diff  = {1'b0, minuend} + {1'b0, ~acc_q} + {8'h00, ~borrow_in};
    assign ndiff = {1'b0, minuend[3:0]} + {1'b0, ~acc_q[3:0]} + {4'h0, ~borrow_in};

    // ****************************************************************
    // Result routing
    // ****************************************************************
    // Literal form lands in the accumulator whatever dest says, unless a same-cycle bus write to it wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            acc_q <= `SSE_ACC_RST;
        end else if (bus_wr && bus_addr == `SSE_OFF_ACC) begin
            acc_q <= bus_wdata;
        end else if (is_sub && (instr.op == SSE_OP_LITERAL_MINUS_ACCUMULATOR
                                || !instr.dest)) begin
            acc_q <= diff[7:0];
        end
    end

    // Register write-back when destination bit is one; the file is cleared on reset
    // so that no register operand is ever unknown, at the cost of a wide reset fan-out
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < `SSE_REG_COUNT; i++) begin
                regs_q[i] <= `SSE_REG_RST;
            end
        end else if (is_sub && instr.op != SSE_OP_LITERAL_MINUS_ACCUMULATOR
                     && instr.dest) begin
            regs_q[instr.reg_addr] <= diff[7:0];
        end
    end

    // Arithmetic flags
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            c_q  <= 1'b0;
            dc_q <= 1'b0;
            z_q  <= 1'b0;
        end else if (is_sub) begin
            c_q  <= diff[8];
            dc_q <= ndiff[4];
            z_q  <= (diff[7:0] == 8'h00);
        end
    end

    // ****************************************************************
    // Power-down and watchdog
    // ****************************************************************
    // Two flip-flops before the wake pin is looked at
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wake_sync_q <= 2'h0;
        end else begin
            wake_sync_q <= {wake_sync_q[0], wake_pin};
        end
    end

    // Sleep state; wake is the only way out short of reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= SSE_RUN;
        end else begin
            case (state_q)
                SSE_RUN: begin
                    if (exec && instr.op == SSE_OP_SLEEP) begin
                        state_q <= SSE_SLEEP;
                    end
                end
                SSE_SLEEP: begin
                    if (wake_sync_q[1]) begin
                        state_q <= SSE_RUN;
                    end
                end
                default: state_q <= SSE_RUN;
            endcase
        end
    end

    // Status bits; reset leaves both high
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            to_n_q <= `SSE_FLAG_N_RST;
            pd_n_q <= `SSE_FLAG_N_RST;
        end else if (exec && instr.op == SSE_OP_SLEEP) begin
            to_n_q <= 1'b1;
            pd_n_q <= 1'b0;
        end
    end

    // Watchdog counts prescaled ticks; power-down clears both stages
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wdt_q <= `SSE_WDT_RST;
            pre_q <= `SSE_PRE_RST;
        end else if (exec && instr.op == SSE_OP_SLEEP) begin
            wdt_q <= 8'h00;
            pre_q <= 8'h00;
        end else if (wdt_tick) begin
            pre_q <= pre_q + 8'h01;
            if (pre_q == 8'hFF) begin
                wdt_q <= wdt_q + 8'h01;
            end
        end
    end

    // ****************************************************************
    // Register bus read
    // ****************************************************************
    // Unmapped offsets read zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (bus_rd) begin
            case (bus_addr)
                `SSE_OFF_ACC:    rdata_q <= acc_q;
                `SSE_OFF_STATUS: rdata_q <= {3'h0, to_n_q, pd_n_q, z_q, dc_q, c_q};
                `SSE_OFF_WDT:    rdata_q <= wdt_q;
                `SSE_OFF_PRE:    rdata_q <= pre_q;
                default:         rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign bus_rdata         = rdata_q;
    assign accumulator       = acc_q;
    assign carry_flag        = c_q;
    assign nibble_carry_flag = dc_q;
    assign zero_flag         = z_q;
    assign timeout_flag_n    = to_n_q;
    assign powerdown_flag_n  = pd_n_q;
    assign osc_run           = (state_q == SSE_RUN);
    assign core_halted       = (state_q == SSE_SLEEP);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_sleep_issue;
        exec && instr.op == SSE_OP_SLEEP;
    endsequence

    property p_lit_result;
        @(posedge sys_clk) disable iff (sys_rst)
        (is_sub && instr.op == SSE_OP_LITERAL_MINUS_ACCUMULATOR && !bus_wr)
        |=> acc_q == $past(instr.literal) - $past(acc_q);
    endproperty
    a_lit_result: assert property (p_lit_result) else $error("literal subtract wrong");

    property p_lit_carry;
        @(posedge sys_clk) disable iff (sys_rst)
        (is_sub && instr.op == SSE_OP_LITERAL_MINUS_ACCUMULATOR)
        |=> c_q == ($past(acc_q) <= $past(instr.literal));
    endproperty
    a_lit_carry: assert property (p_lit_carry) else $error("literal carry wrong");

    property p_reg_to_acc;
        @(posedge sys_clk) disable iff (sys_rst)
        (is_sub && instr.op == SSE_OP_REGISTER_MINUS_ACCUMULATOR && !instr.dest && !bus_wr)
        |=> acc_q == $past(minuend) - $past(acc_q);
    endproperty
    a_reg_to_acc: assert property (p_reg_to_acc) else $error("register subtract wrong");

    // Register destination takes the difference and leaves the accumulator alone
    property p_reg_to_reg;
        @(posedge sys_clk) disable iff (sys_rst)
        (is_sub && instr.op == SSE_OP_REGISTER_MINUS_ACCUMULATOR && instr.dest && !bus_wr)
        |=> regs_q[$past(instr.reg_addr)] == $past(minuend) - $past(acc_q)
            && $stable(acc_q);
    endproperty
    a_reg_to_reg: assert property (p_reg_to_reg) else $error("register write-back wrong");

    property p_reg_carry;
        @(posedge sys_clk) disable iff (sys_rst)
        (is_sub && instr.op == SSE_OP_REGISTER_MINUS_ACCUMULATOR)
        |=> c_q == ($past(acc_q) <= $past(minuend));
    endproperty
    a_reg_carry: assert property (p_reg_carry) else $error("register carry wrong");

    property p_nibble;
        @(posedge sys_clk) disable iff (sys_rst)
        (is_sub && instr.op == SSE_OP_REGISTER_MINUS_ACCUMULATOR)
        |=> dc_q == ($past(acc_q[3:0]) <= $past(minuend[3:0]));
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble carry wrong");

    property p_borrow;
        @(posedge sys_clk) disable iff (sys_rst)
        (is_sub && instr.op == SSE_OP_REGISTER_MINUS_ACCUMULATOR_BORROW && !instr.dest
         && !bus_wr)
        |=> acc_q == $past(minuend) - $past(acc_q) - {7'h00, ~$past(c_q)};
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow subtract wrong");

    property p_sleep_flags;
        @(posedge sys_clk) disable iff (sys_rst)
        s_sleep_issue |=> !pd_n_q && to_n_q;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep status wrong");

    property p_sleep_wdt;
        @(posedge sys_clk) disable iff (sys_rst)
        s_sleep_issue |=> wdt_q == 8'h00 && pre_q == 8'h00;
    endproperty
    a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog not cleared");

    property p_sleep_halt;
        @(posedge sys_clk) disable iff (sys_rst)
        s_sleep_issue ##1 !wake_sync_q[1] |-> !osc_run && core_halted;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) else $error("core not halted");

    // Zero flag held against a difference formed apart from the adder above
    property p_zero;
        @(posedge sys_clk) disable iff (sys_rst)
        is_sub |=> z_q == (($past(minuend) - $past(acc_q)
                            - {7'h00, $past(instr.op == SSE_OP_REGISTER_MINUS_ACCUMULATOR_BORROW
                                            && !c_q)}) == 8'h00)
                   && $stable(to_n_q);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule : sse_exec

/* sim/sse_exec_tb.sv */
// Self-checking testbench for the subtract and sleep execution block
`timescale 1ns/1ps
`include "sse_defines.svh"

module sse_exec_tb
    import sse_pkg::*;
();
    // ****************************************************************
    // Signals and model state
    // ****************************************************************
    logic          sys_clk, sys_rst, instr_valid, wake_pin, wdt_tick;
    logic          bus_wr, bus_rd, rd_pend;
    sse_instr_type instr;
    logic [7:0]    bus_addr, bus_wdata, bus_rdata, accumulator;
    logic          carry_flag, nibble_carry_flag, zero_flag;
    logic          timeout_flag_n, powerdown_flag_n, osc_run, core_halted;
    logic [7:0]    exp_q[$];
    logic [7:0]    mw, mreg;
    logic          mc, mdc, mz, mpd;
    int            n_errors, n_checks;
    // Boundary pairs: accumulator above, equal, below, nibble edge, extremes
    logic [7:0]    tw[6] = '{8'h05, 8'h03, 8'h03, 8'h0F, 8'hFF, 8'h00};
    logic [7:0]    tk[6] = '{8'h03, 8'h03, 8'h05, 8'h10, 8'h00, 8'hFF};

    sse_exec sse_exec_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
        .wake_pin(wake_pin), .wdt_tick(wdt_tick), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .accumulator(accumulator), .carry_flag(carry_flag),
        .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag),
        .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
        .osc_run(osc_run), .core_halted(core_halted)
    );

    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;

    // Read data stands only in the cycle after the strobe, so look mid-cycle
    always @(posedge sys_clk) rd_pend <= bus_rd;
    always @(negedge sys_clk) begin
        if (rd_pend === 1'h1) begin
            if (exp_q.size() == 0) fail("read data with no expectation");
            else chk(bus_rdata, exp_q.pop_front(), "read data mismatch");
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic fail(input string m);
        n_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_checks++;
        if (got !== exp) fail(m);
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    // One bus cycle; every bus and instruction input assigned once (not wake_pin or wdt_tick) so back-to-back calls never clash
    task automatic cyc(input logic w, input logic r, input logic v,
                       input logic [7:0] a, input logic [7:0] d, input sse_instr_type i);
        bus_wr      <= w;
        bus_rd      <= r;
        instr_valid <= v;
        bus_addr    <= a;
        bus_wdata   <= d;
        instr       <= i;
        @(posedge sys_clk);
    endtask : cyc

    task automatic idle(input int n);
        repeat (n) cyc(1'h0, 1'h0, 1'h0, 8'h00, 8'h00, '0);
    endtask : idle

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cyc(1'h0, 1'h1, 1'h0, a, 8'h00, '0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1'h1, 1'h0, 1'h0, a, d, '0);
        if (a == `SSE_OFF_ACC) mw = d;
    endtask : wr

    function automatic sse_instr_type mk(input sse_op_type o, input logic [7:0] k,
                                         input logic d);
        return '{o, k, 7'h05, d};
    endfunction : mk

    function automatic logic [7:0] st();
        return {3'h0, 1'h1, mpd, mz, mdc, mc};
    endfunction : st

    // Model of all three subtracts; carry and nibble carry set means no borrow
    task automatic sub(input sse_op_type o, input logic [7:0] k, input logic d,
                       input logic look);
        logic [7:0] m;
        logic [8:0] r;
        logic [4:0] n;
        logic       b;
        m   = (o == SSE_OP_LITERAL_MINUS_ACCUMULATOR) ? k : mreg;
        b   = (o == SSE_OP_REGISTER_MINUS_ACCUMULATOR_BORROW) && !mc;
        r   = {1'h0, m} - {1'h0, mw} - {8'h00, b};
        n   = {1'h0, m[3:0]} - {1'h0, mw[3:0]} - {4'h0, b};
        mc  = !r[8];
        mdc = !n[4];
        mz  = (r[7:0] == 8'h00);
        cyc(1'h0, 1'h0, 1'h1, 8'h00, 8'h00, mk(o, k, d));
        if (o == SSE_OP_LITERAL_MINUS_ACCUMULATOR || !d) mw = r[7:0];
        else mreg = r[7:0];
        if (look) begin
            rd(`SSE_OFF_ACC, mw);
            rd(`SSE_OFF_STATUS, st());
            chk(accumulator, mw, "accumulator output wrong");
            chk({3'h0, timeout_flag_n, powerdown_flag_n, zero_flag, nibble_carry_flag,
                 carry_flag}, st(), "flag outputs wrong");
        end
    endtask : sub

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        sys_clk = 1'h0; sys_rst = 1'h1; instr_valid = 1'h0; instr = '0;
        wake_pin = 1'h0; wdt_tick = 1'h0; bus_wr = 1'h0; bus_rd = 1'h0;
        bus_addr = 8'h00; bus_wdata = 8'h00;
        mw = 8'h00; mc = 1'h0; mdc = 1'h0; mz = 1'h0; mpd = 1'h1;
        mreg = 8'h00;
        n_errors = 0; n_checks = 0;
        void'($urandom(25528));
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'h0;
        // Reset values, an unmapped address and an ignored status write
        rd(`SSE_OFF_ACC, 8'h00);
        rd(`SSE_OFF_STATUS, 8'h18);
        rd(`SSE_OFF_WDT, 8'h00);
        rd(`SSE_OFF_PRE, 8'h00);
        rd(8'h7E, 8'h00);
        wr(`SSE_OFF_STATUS, 8'hFF);
        rd(`SSE_OFF_STATUS, st());
        // Boundary cases, then random operands
        for (int j = 0; j < 6; j++) begin
            wr(`SSE_OFF_ACC, tw[j]);
            sub(SSE_OP_LITERAL_MINUS_ACCUMULATOR, tk[j], 1'h0, 1'h1);
        end
        repeat (24) begin
            wr(`SSE_OFF_ACC, 8'($urandom()));
            sub(SSE_OP_LITERAL_MINUS_ACCUMULATOR, 8'($urandom()), 1'h0, 1'h1);
        end
        // Back-to-back issue: second sees the first result
        sub(SSE_OP_LITERAL_MINUS_ACCUMULATOR, 8'($urandom()), 1'h0, 1'h0);
        sub(SSE_OP_LITERAL_MINUS_ACCUMULATOR, 8'($urandom()), 1'h0, 1'h1);
        // Bus write to the accumulator wins over a same-cycle subtract
        cyc(1'h1, 1'h0, 1'h1, `SSE_OFF_ACC, 8'h5A,
            mk(SSE_OP_LITERAL_MINUS_ACCUMULATOR, 8'h33, 1'h0));
        mw = 8'h5A;
        rd(`SSE_OFF_ACC, mw);
        // Flags from the overridden subtract are not modelled; a fresh one resets them
        sub(SSE_OP_LITERAL_MINUS_ACCUMULATOR, 8'h80, 1'h0, 1'h1);
        // Register forms aimed at the register leave the accumulator alone
        sub(SSE_OP_REGISTER_MINUS_ACCUMULATOR, 8'h00, 1'h1, 1'h0);
        sub(SSE_OP_REGISTER_MINUS_ACCUMULATOR_BORROW, 8'h00, 1'h1, 1'h0);
        rd(`SSE_OFF_ACC, mw);
        // Both register forms to both destinations, with either carry pending
        for (int j = 0; j < 16; j++) begin
            wr(`SSE_OFF_ACC, 8'($urandom()));
            sub(j[0] ? SSE_OP_REGISTER_MINUS_ACCUMULATOR_BORROW
                     : SSE_OP_REGISTER_MINUS_ACCUMULATOR, 8'h00, j[1], 1'h1);
        end
        // Borrow form right behind a register form uses the fresh carry
        sub(SSE_OP_REGISTER_MINUS_ACCUMULATOR, 8'h00, 1'h1, 1'h0);
        sub(SSE_OP_REGISTER_MINUS_ACCUMULATOR_BORROW, 8'h00, 1'h0, 1'h1);
        sub(SSE_OP_LITERAL_MINUS_ACCUMULATOR, 8'h80, 1'h0, 1'h1);
        // Prescaler wraps once into the watchdog count
        wdt_tick <= 1'h1;
        idle(259);
        wdt_tick <= 1'h0;
        rd(`SSE_OFF_PRE, 8'h03);
        rd(`SSE_OFF_WDT, 8'h01);
        // Power-down
        cyc(1'h0, 1'h0, 1'h1, 8'h00, 8'h00, mk(SSE_OP_SLEEP, 8'h00, 1'h0));
        mpd = 1'h0;
        #1;
        chk({7'h00, osc_run}, 8'h00, "oscillator still running");
        chk({7'h00, core_halted}, 8'h01, "core not halted");
        rd(`SSE_OFF_WDT, 8'h00);
        rd(`SSE_OFF_PRE, 8'h00);
        rd(`SSE_OFF_STATUS, st());
        // Instructions while asleep are dropped
        cyc(1'h0, 1'h0, 1'h1, 8'h00, 8'h00, mk(SSE_OP_LITERAL_MINUS_ACCUMULATOR, 8'h11, 1'h0));
        rd(`SSE_OFF_ACC, mw);
        // Wake within a bounded wait
        wake_pin <= 1'h1;
        for (int j = 0; j < 8 && osc_run !== 1'h1; j++) idle(1);
        if (osc_run !== 1'h1) begin
            fail("no wake from sleep");
            end_of_test();
        end
        wake_pin <= 1'h0;
        chk({7'h00, core_halted}, 8'h00, "core still halted");
        sub(SSE_OP_LITERAL_MINUS_ACCUMULATOR, 8'h42, 1'h0, 1'h0);
        rd(`SSE_OFF_ACC, mw);
        idle(3);
        if (exp_q.size() != 0) fail("reads left unanswered");
        end_of_test();
    end
endmodule : sse_exec_tb
